/* File: asb_host_model.sv */
// Bus host model: drives clock and data open drain, reads back the wired line
`timescale 1ns/1ps
module asb_host_model (
  // Bus lines, high means released to the pull-up
  output logic scl,
  output logic sda,
  input wire logic sda_line
);
  localparam real H = 62.5;
  // Clock stands high between frames
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic start();
    sda = 1'b1;
    #H;
    scl = 1'b1;
    #H;
    sda = 1'b0;
    #H;
    scl = 1'b0;
  endtask
  task automatic stop();
    #(H/4);
    sda = 1'b0;
    #H;
    scl = 1'b1;
    #H;
    sda = 1'b1;
    #H;
  endtask
  // Data moves a quarter of the low phase after the fall so no false START or STOP is seen
  task automatic xfer(input logic b, output logic r);
    #(H/4);
    sda = b;
    #(3*H/4);
    scl = 1'b1;
    #(H/2);
    r = sda_line;
    #(H/2);
    scl = 1'b0;
  endtask
  task automatic wr_byte(input logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--)
      xfer(v[i], ack);
    xfer(1'b1, ack);
  endtask
  // Rival bits stand for a lower-address device answering at the same time
  task automatic rd_byte(input logic [7:0] rival, input logic last, output logic [7:0] v);
    logic a;
    for (int i = 7; i >= 0; i--)
      xfer(rival[i], v[i]);
    xfer(last, a);
  endtask
endmodule // asb_host_model

/* File: asb_line_if.sv */
// Interface carrying the filtered bus lines and detected conditions
`timescale 1ns/1ps
interface asb_line_if;
  logic scl;
  logic sda;
  logic alert;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;

  modport mon (
    output scl,
    output sda,
    output alert,
    output scl_rise,
    output scl_fall,
    output start,
    output stop
  );

  modport core (
    input scl,
    input sda,
    input alert,
    input scl_rise,
    input scl_fall,
    input start,
    input stop
  );
endinterface

/* File: asb_line_monitor.sv */
// Pin synchronisers and START/STOP/edge detection for the bus lines
`timescale 1ns/1ps
module asb_line_monitor
  import asb_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Raw pins
  input wire logic scl_pin,
  input wire logic sda_pin,
  input wire logic alert_pin,
  // Filtered lines
  asb_line_if.mon ln
);

  // ==========================================================================
  // Three-stage synchronisers
  logic [SYNC_LINES-1:0] raw;
  logic [SYNC_LINES-1:0] s1;
  logic [SYNC_LINES-1:0] s2;
  logic [SYNC_LINES-1:0] s3;
  logic [SYNC_LINES-1:0] flt;
  logic [SYNC_LINES-1:0] flt_d;

  assign raw[LINE_SCL] = scl_pin;
  assign raw[LINE_SDA] = sda_pin;
  assign raw[LINE_ALERT] = alert_pin;

  genvar g;
  generate
    for (g = 0; g < SYNC_LINES; g++) begin : g_sync
      // A change counts only when the last two stages agree
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1[g] <= 1'b1;
          s2[g] <= 1'b1;
          s3[g] <= 1'b1;
          flt[g] <= 1'b1;
          flt_d[g] <= 1'b1;
        end else begin
          s1[g] <= raw[g];
          s2[g] <= s1[g];
          s3[g] <= s2[g];
          if (s2[g] == s3[g]) begin
            flt[g] <= s3[g];
          end
          flt_d[g] <= flt[g];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Conditions
  assign ln.scl = flt[LINE_SCL];
  assign ln.sda = flt[LINE_SDA];
  assign ln.alert = flt[LINE_ALERT];
  assign ln.scl_rise = flt[LINE_SCL] & ~flt_d[LINE_SCL];
  assign ln.scl_fall = ~flt[LINE_SCL] & flt_d[LINE_SCL];
  assign ln.start = flt[LINE_SCL] & flt_d[LINE_SCL] & flt_d[LINE_SDA] & ~flt[LINE_SDA];
  assign ln.stop = flt[LINE_SCL] & flt_d[LINE_SCL] & ~flt_d[LINE_SDA] & flt[LINE_SDA];

endmodule // asb_line_monitor

/* File: asb_pkg.sv */
// Package of constants and types for the alert and suspend sideband block
package asb_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int CLK_PERIOD_NS = 4;
  // The suspend indicator may fall right after STOP
  localparam int T_STOP2SUS_NS = 0;
  localparam int STOP2SUS_CYCLES = (T_STOP2SUS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // Bus framing
  localparam int BYTE_BITS = 8;
  localparam int RW_BIT = 0;
  localparam int ADDR_MSB = 7;
  localparam int ADDR_LSB = 1;
  localparam int SYNC_LINES = 3;
  localparam int LINE_SCL = 0;
  localparam int LINE_SDA = 1;
  localparam int LINE_ALERT = 2;

  // ==========================================================================
  // Addresses and byte values
  localparam logic [6:0] ARA_ADDR = 7'h0C;
  localparam logic ARA_FILL_BIT = 1'b1;
  localparam logic RW_READ = 1'b1;
  localparam logic RW_WRITE = 1'b0;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ZERO = 4'h0;

  // ==========================================================================
  // Slave engine states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_CFG,
    ST_CFG_ACK,
    ST_TX,
    ST_TX_ACK,
    ST_PEC_LOAD,
    ST_SKIP
  } asb_state_e;

endpackage

/* File: asb_sideband.sv */
// Top of the suspend and alert sideband block with its alert-response slave
`timescale 1ns/1ps
module asb_sideband (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Bus pins
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // Alert pin
  input wire logic ALERT_N_IN,
  output logic ALERT_N_OUT,
  output logic ALERT_N_OE,
  // Suspend control
  input wire logic SUSPEND_REQ,
  output logic SUSPEND_INDICATOR_N,
  output logic WAKE_REQ,
  output logic [7:0] SUSPEND_ACTION,
  // Device settings and status
  input wire logic [6:0] DEV_ADDR,
  input wire logic PEC_EN,
  input wire logic ALERT_REQ,
  output logic ALERT_PENDING,
  output logic ALERT_SERVED,
  output logic ARB_LOST,
  output logic ALERT_LINE_LOW,
  output logic BUS_ALIVE,
  output logic [7:0] CFG_VALUE
);
  import asb_pkg::*;

  // ==========================================================================
  // Line monitor
  asb_line_if ln ();

  asb_line_monitor u_mon (
    .clk(CLOCK),
    .rst_n(RST_N),
    .scl_pin(SCL_IN),
    .sda_pin(SDA_IN),
    .alert_pin(ALERT_N_IN),
    .ln(ln)
  );

  // ==========================================================================
  // CRC-8 used for the packet error code
  function automatic logic [7:0] crc8(input logic [7:0] crc_in, input logic [7:0] data);
    logic [7:0] c;
    c = crc_in ^ data;
    for (int i = 0; i < BYTE_BITS; i++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  // ==========================================================================
  // State
  asb_state_e state;
  logic [3:0] bit_cnt;
  logic [7:0] rx_sh;
  logic [7:0] tx_sh;
  logic [7:0] pec_byte;
  logic pec_due;
  logic sending_addr;
  logic ack_on;
  logic is_read;
  logic bus_busy;
  logic suspended;
  logic alert_pend;
  logic [7:0] cfg;

  // ==========================================================================
  // Decode of the byte being received
  wire [7:0] rx_next = {rx_sh[6:0], ln.sda};
  wire byte_done = (bit_cnt == BIT_LAST);
  wire hit_ara = (rx_next[ADDR_MSB:ADDR_LSB] == ARA_ADDR) && (rx_next[RW_BIT] == RW_READ) && alert_pend;
  wire hit_own = (rx_next[ADDR_MSB:ADDR_LSB] == DEV_ADDR) && (rx_next[RW_BIT] == RW_WRITE);
  wire may_answer = !suspended;
  wire [7:0] ara_reply = {DEV_ADDR, ARA_FILL_BIT};
  wire [7:0] ara_crc = crc8(crc8(CRC_INIT, {ARA_ADDR, RW_READ}), ara_reply);
  wire lost_bit = ~SDA_OE & tx_sh[7] & ~ln.sda;
  wire won_byte = (state == ST_TX) && ln.scl_rise && byte_done && !lost_bit && sending_addr;
  wire bus_idle_now = !bus_busy && !ln.start;
  wire enter_susp = SUSPEND_REQ && !suspended && bus_idle_now && !WAKE_REQ;
  wire leave_susp = !SUSPEND_REQ && suspended;
  wire wake_seen = suspended && ln.start;

  // ==========================================================================
  // Slave engine
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state <= ST_IDLE;
      bit_cnt <= BIT_ZERO;
      rx_sh <= 8'h00;
      tx_sh <= 8'h00;
      pec_byte <= CRC_INIT;
      pec_due <= 1'b0;
      sending_addr <= 1'b0;
      ack_on <= 1'b0;
      is_read <= 1'b0;
      cfg <= CFG_RESET;
      SDA_OE <= 1'b0;
      ARB_LOST <= 1'b0;
    end else begin
      ARB_LOST <= 1'b0;
      if (ln.start) begin
        // Repeated START restarts address reception
        state <= ST_ADDR;
        bit_cnt <= BIT_ZERO;
        ack_on <= 1'b0;
        SDA_OE <= 1'b0;
      end else if (ln.stop) begin
        state <= ST_IDLE;
        ack_on <= 1'b0;
        SDA_OE <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            SDA_OE <= 1'b0;
          end
          ST_ADDR: begin
            if (ln.scl_rise) begin
              rx_sh <= rx_next;
              bit_cnt <= bit_cnt + 4'h1;
              if (byte_done) begin
                bit_cnt <= BIT_ZERO;
                is_read <= hit_ara;
                if (may_answer && (hit_ara || hit_own)) begin
                  state <= ST_ADDR_ACK;
                end else begin
                  state <= ST_SKIP;
                end
              end
            end
          end
          ST_ADDR_ACK: begin
            if (ln.scl_fall) begin
              if (!ack_on) begin
                ack_on <= 1'b1;
                SDA_OE <= 1'b1;
              end else if (is_read) begin
                // Drive the first reply bit at the end of the ack slot
                ack_on <= 1'b0;
                tx_sh <= ara_reply;
                SDA_OE <= ~ara_reply[7];
                pec_byte <= ara_crc;
                pec_due <= PEC_EN;
                sending_addr <= 1'b1;
                state <= ST_TX;
              end else begin
                ack_on <= 1'b0;
                SDA_OE <= 1'b0;
                state <= ST_CFG;
              end
            end
          end
          ST_CFG: begin
            if (ln.scl_rise) begin
              rx_sh <= rx_next;
              bit_cnt <= bit_cnt + 4'h1;
              if (byte_done) begin
                bit_cnt <= BIT_ZERO;
                cfg <= rx_next;
                state <= ST_CFG_ACK;
              end
            end
          end
          ST_CFG_ACK: begin
            if (ln.scl_fall) begin
              ack_on <= ~ack_on;
              SDA_OE <= ~ack_on;
              if (ack_on) begin
                // One settings byte per message; further bytes are not acknowledged
                state <= ST_SKIP;
              end
            end
          end
          ST_TX: begin
            if (ln.scl_rise) begin
              if (lost_bit) begin
                // Lower address on the wire wins; stop driving at once
                SDA_OE <= 1'b0;
                ARB_LOST <= 1'b1;
                state <= ST_SKIP;
              end else if (byte_done) begin
                bit_cnt <= BIT_ZERO;
                state <= ST_TX_ACK;
              end else begin
                bit_cnt <= bit_cnt + 4'h1;
              end
            end else if (ln.scl_fall) begin
              tx_sh <= {tx_sh[6:0], 1'b0};
              SDA_OE <= ~tx_sh[6];
            end
          end
          ST_TX_ACK: begin
            if (ln.scl_fall) begin
              SDA_OE <= 1'b0;
            end else if (ln.scl_rise) begin
              sending_addr <= 1'b0;
              if (!ln.sda && pec_due) begin
                state <= ST_PEC_LOAD;
              end else begin
                state <= ST_SKIP;
              end
            end
          end
          ST_PEC_LOAD: begin
            if (ln.scl_fall) begin
              tx_sh <= pec_byte;
              SDA_OE <= ~pec_byte[7];
              pec_due <= 1'b0;
              state <= ST_TX;
            end
          end
          ST_SKIP: begin
            SDA_OE <= 1'b0;
          end
          default: begin
            state <= ST_IDLE;
            SDA_OE <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Alert request
  // A new request in the same cycle as the release keeps the line pulled
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      alert_pend <= 1'b0;
      ALERT_SERVED <= 1'b0;
    end else begin
      ALERT_SERVED <= won_byte;
      if (ALERT_REQ) begin
        alert_pend <= 1'b1;
      end else if (won_byte) begin
        alert_pend <= 1'b0;
      end
    end
  end

  // Open drain: output data is always low, only the enable moves
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ALERT_N_OUT <= 1'b0;
      ALERT_N_OE <= 1'b0;
      SDA_OUT <= 1'b0;
      ALERT_PENDING <= 1'b0;
      ALERT_LINE_LOW <= 1'b0;
    end else begin
      ALERT_N_OUT <= 1'b0;
      SDA_OUT <= 1'b0;
      ALERT_N_OE <= alert_pend;
      ALERT_PENDING <= alert_pend;
      ALERT_LINE_LOW <= ~ln.alert;
    end
  end

  // ==========================================================================
  // Suspend indicator
  // Busy from START to STOP; suspend may only begin in the gap
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      bus_busy <= 1'b0;
    end else if (ln.start) begin
      bus_busy <= 1'b1;
    end else if (ln.stop) begin
      bus_busy <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      suspended <= 1'b0;
      SUSPEND_INDICATOR_N <= 1'b1;
    end else if (enter_susp) begin
      suspended <= 1'b1;
      SUSPEND_INDICATOR_N <= 1'b0;
    end else if (leave_susp) begin
      suspended <= 1'b0;
      SUSPEND_INDICATOR_N <= 1'b1;
    end
  end

  // Wake request holds until the system withdraws its suspend request,
  // so a START-triggered resume cannot fall straight back into suspend
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      WAKE_REQ <= 1'b0;
    end else if (wake_seen) begin
      WAKE_REQ <= 1'b1;
    end else if (!SUSPEND_REQ) begin
      WAKE_REQ <= 1'b0;
    end
  end

  // ==========================================================================
  // Status outputs
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      SUSPEND_ACTION <= CFG_RESET;
      CFG_VALUE <= CFG_RESET;
      BUS_ALIVE <= 1'b0;
    end else begin
      SUSPEND_ACTION <= suspended ? cfg : CFG_RESET;
      CFG_VALUE <= cfg;
      BUS_ALIVE <= ln.scl & ln.sda;
    end
  end

endmodule // asb_sideband

/* File: asb_sideband_props.sv */
// Concurrent checks on the sideband block ports
`timescale 1ns/1ps
module asb_sideband_props (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Bus pins
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  // Alert pin
  input wire logic ALERT_N_OUT,
  input wire logic ALERT_N_OE,
  // Suspend control
  input wire logic SUSPEND_REQ,
  input wire logic SUSPEND_INDICATOR_N,
  input wire logic WAKE_REQ,
  input wire logic [7:0] SUSPEND_ACTION,
  // Status
  input wire logic ALERT_REQ,
  input wire logic ALERT_PENDING,
  input wire logic ALERT_SERVED,
  input wire logic ARB_LOST,
  input wire logic BUS_ALIVE
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);
  // ==========================================================================
  // Sequences
  sequence s_raised;
    ##2 ALERT_PENDING && ALERT_N_OE;
  endsequence
  sequence s_released;
    ##[1:2] !ALERT_N_OE;
  endsequence
  // ==========================================================================
  // Alert and bus
  a_alert_raise: assert property (ALERT_REQ |-> s_raised)
    else $error("alert not raised two cycles after request");
  a_open_drain: assert property (SDA_OUT == 1'b0 && ALERT_N_OUT == 1'b0)
    else $error("open drain pin drives high");
  a_alert_release: assert property (ALERT_SERVED |-> s_released)
    else $error("alert kept after address went out");
  a_lost_quiet: assert property (ARB_LOST |-> ALERT_PENDING ##1 !SDA_OE [*2])
    else $error("data still driven or alert dropped after lost arbitration");
  a_bus_alive: assert property ((SCL_IN && SDA_IN) [*7] |-> BUS_ALIVE)
    else $error("bus not alive with both lines high");
  a_bus_busy: assert property (!SDA_IN [*7] |-> !BUS_ALIVE)
    else $error("bus alive with data low");
  // ==========================================================================
  // Suspend
  a_susp_quiet: assert property (!SUSPEND_INDICATOR_N |-> !SDA_OE)
    else $error("bus answered while suspended");
  a_susp_cause: assert property ($fell(SUSPEND_INDICATOR_N) |-> $past(SUSPEND_REQ) && !$past(WAKE_REQ))
    else $error("suspend entered without request");
  a_susp_leave: assert property (!SUSPEND_REQ |=> SUSPEND_INDICATOR_N && !WAKE_REQ)
    else $error("suspend not left one cycle after request drop");
  a_wake_cause: assert property ($rose(WAKE_REQ) |-> !$past(SUSPEND_INDICATOR_N))
    else $error("wake raised outside suspend");
  a_action_idle: assert property (SUSPEND_INDICATOR_N && $past(SUSPEND_INDICATOR_N) |-> SUSPEND_ACTION == 8'h00)
    else $error("suspend action shown while awake");
endmodule // asb_sideband_props
bind asb_sideband asb_sideband_props u_props (
  .CLOCK(CLOCK), .RST_N(RST_N), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
  .ALERT_N_OUT(ALERT_N_OUT), .ALERT_N_OE(ALERT_N_OE), .SUSPEND_REQ(SUSPEND_REQ),
  .SUSPEND_INDICATOR_N(SUSPEND_INDICATOR_N), .WAKE_REQ(WAKE_REQ), .SUSPEND_ACTION(SUSPEND_ACTION),
  .ALERT_REQ(ALERT_REQ), .ALERT_PENDING(ALERT_PENDING), .ALERT_SERVED(ALERT_SERVED), .ARB_LOST(ARB_LOST),
  .BUS_ALIVE(BUS_ALIVE)
);

/* File: tb.sv */
// Self-checking bench for the alert and suspend sideband block
`timescale 1ns/1ps
module tb;
  import asb_pkg::*;
  localparam logic [6:0] ADDR = 7'h2A;
  localparam logic [7:0] REPLY = {ADDR, ARA_FILL_BIT};
  localparam int LIMIT = 20000;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic susp_req = 1'b0;
  logic pec_en = 1'b0;
  logic alert_req = 1'b0;
  logic [6:0] dev_addr = ADDR;
  logic other_n = 1'b1;
  logic lost = 1'b0;
  logic won = 1'b0;
  logic scl, sda, sda_oe, sda_out, al_n_oe, al_n_out, susp_n, wake, pend, served, arb_lost, line_low, alive;
  logic [7:0] action, cfg, d;
  logic ack;
  int failures = 0;
  int comparisons = 0;
  int ticks = 0;
  // Wired-AND lines with pull-ups: released means high
  wire logic sda_line = sda & ~sda_oe;
  wire logic alert_n_line = ~al_n_oe & other_n;
  always #2 clock = ~clock;
  asb_host_model host (.scl(scl), .sda(sda), .sda_line(sda_line));
  asb_sideband DUT (
    .CLOCK(clock), .RST_N(rst_n), .SCL_IN(scl), .SDA_IN(sda_line), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .ALERT_N_IN(alert_n_line), .ALERT_N_OUT(al_n_out), .ALERT_N_OE(al_n_oe), .SUSPEND_REQ(susp_req),
    .SUSPEND_INDICATOR_N(susp_n), .WAKE_REQ(wake), .SUSPEND_ACTION(action), .DEV_ADDR(dev_addr),
    .PEC_EN(pec_en), .ALERT_REQ(alert_req), .ALERT_PENDING(pend), .ALERT_SERVED(served),
    .ARB_LOST(arb_lost), .ALERT_LINE_LOW(line_low), .BUS_ALIVE(alive), .CFG_VALUE(cfg)
  );
  // ==========================================================================
  // Helpers
  task automatic conclude();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clock) begin
    ticks <= ticks + 1;
    if (arb_lost === 1'b1)
      lost <= 1'b1;
    // Served is a one-cycle pulse, so it is latched here
    if (served === 1'b1)
      won <= 1'b1;
    if (ticks == LIMIT) begin
      failures++;
      conclude();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++)
      r = r[7] ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
    return r;
  endfunction
  task automatic raise();
    @(posedge clock);
    alert_req <= 1'b1;
    @(posedge clock);
    alert_req <= 1'b0;
    cyc(8);
    chk(al_n_oe, 1'b1);
    chk(line_low, 1'b1);
  endtask
  task automatic ara(input logic [7:0] rival, input logic last);
    host.start();
    host.wr_byte({ARA_ADDR, RW_READ}, ack);
    host.rd_byte(rival, last, d);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_alert();
    won = 1'b0;
    raise();
    ara(8'hFF, 1'b1);
    host.stop();
    cyc(8);
    chk(ack, 1'b0);
    chk(d, REPLY);
    chk(al_n_oe, 1'b0);
    chk(won, 1'b1);
    chk(pend, 1'b0);
    chk(line_low, 1'b0);
    ara(8'hFF, 1'b1);
    host.stop();
    chk(ack, 1'b1);
    $display("test alert done");
  endtask
  task automatic t_arb();
    lost = 1'b0;
    @(posedge clock);
    other_n <= 1'b0;
    raise();
    ara(8'h41, 1'b1);
    host.stop();
    cyc(8);
    chk(d, 8'h41);
    chk(lost, 1'b1);
    chk(al_n_oe, 1'b1);
    chk(pend, 1'b1);
    ara(8'hFF, 1'b1);
    host.stop();
    cyc(8);
    chk(d, REPLY);
    chk(al_n_oe, 1'b0);
    chk(line_low, 1'b1);
    @(posedge clock);
    other_n <= 1'b1;
    $display("test arbitration done");
  endtask
  task automatic t_pec();
    @(posedge clock);
    pec_en <= 1'b1;
    raise();
    ara(8'hFF, 1'b0);
    chk(d, REPLY);
    host.rd_byte(8'hFF, 1'b1, d);
    host.stop();
    chk(d, crc8(crc8(CRC_INIT, {ARA_ADDR, RW_READ}), REPLY));
    @(posedge clock);
    pec_en <= 1'b0;
    $display("test pec done");
  endtask
  task automatic t_susp();
    host.start();
    host.wr_byte({ADDR, RW_WRITE}, ack);
    chk(ack, 1'b0);
    // Suspend asked for mid-message must wait for the STOP
    @(posedge clock);
    susp_req <= 1'b1;
    cyc(3);
    chk(susp_n, 1'b1);
    host.wr_byte(8'hA5, ack);
    chk(ack, 1'b0);
    host.wr_byte(8'h3C, ack);
    chk(ack, 1'b1);
    host.stop();
    cyc(3);
    chk(susp_n, 1'b0);
    chk(cfg, 8'hA5);
    chk(action, 8'hA5);
    host.start();
    chk(alive, 1'b0);
    host.wr_byte({ADDR, RW_WRITE}, ack);
    host.stop();
    chk(ack, 1'b1);
    chk(wake, 1'b1);
    @(posedge clock);
    susp_req <= 1'b0;
    cyc(3);
    chk(susp_n, 1'b1);
    chk(wake, 1'b0);
    chk(action, 8'h00);
    $display("test suspend done");
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    cyc(6);
    chk(susp_n, 1'b1);
    chk(sda_oe, 1'b0);
    chk(alive, 1'b1);
    t_alert();
    t_arb();
    t_pec();
    t_susp();
    conclude();
  end
endmodule // tb
